// >>> test/watchdog_interval_timer_regs_test.sv
// Testbench: register access, interval and watchdog overflow, standby
module watchdog_interval_timer_regs_test;
  import wdt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic standby = 1'b0;
  bus_req_type req;
  logic [7:0] rdata;
  logic hit, ovf_n, chip_rst, man_rst, irq;
  int num_errors = 0;
  int tests_run = 0;

  always #2 mclk = ~mclk;

  wdt_top u_wdt_top (
    .MCLK_IN(mclk), .RESET_N_IN(reset_n), .STANDBY_IN(standby),
    .BUS_VALID_IN(req.valid), .BUS_WRITE_IN(req.write), .BUS_SIZE_IN(req.size),
    .BUS_ADDR_IN(req.addr), .BUS_WDATA_IN(req.wdata), .BUS_RDATA_OUT(rdata),
    .BUS_HIT_OUT(hit), .OVERFLOW_OUT_N_OUT(ovf_n), .CHIP_RESET_OUT(chip_rst),
    .MANUAL_RESET_OUT(man_rst), .INTERVAL_INTERRUPT_OUT(irq)
  );
  wdt_cpu_model u_wdt_cpu_model (.clk_in(mclk), .rdata_in(rdata), .req_out(req));

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  task automatic wr(input logic [27:0] a, input logic [15:0] d);
    u_wdt_cpu_model.access(1'b1, XFER_WORD, a, d);
    // Let the write land before anyone looks at outputs
    #1;
  endtask

  task automatic rdchk(input logic [27:0] a, input logic [7:0] exp, input string m);
    logic [7:0] d;
    u_wdt_cpu_model.rd(a, d);
    chk(d, exp, m);
  endtask

  // Bounded wait for an overflow reaction; slow clock taps never get here
  task automatic wait_for(input logic want_irq);
    for (int i = 0; i < 40 && (want_irq ? irq !== 1'b1 : ovf_n !== 1'b0); i++) begin
      @(posedge mclk);
    end
    #1;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    rdchk(ADDR_MODE_CTRL, 8'h18, "control reset");
    rdchk(ADDR_COUNT_RD, 8'h00, "count reset");
    rdchk(ADDR_RST_CTRL_RD, 8'h1f, "reset control reset");
  endtask

  task automatic t_keyed_writes;
    wr(ADDR_MODE_CTRL, 16'h5a42);
    rdchk(ADDR_COUNT_RD, 8'h00, "disabled count held");
    wr(ADDR_MODE_CTRL, 16'ha527);
    u_wdt_cpu_model.access(1'b1, XFER_BYTE, ADDR_MODE_CTRL, 16'ha500);
    rdchk(ADDR_MODE_CTRL, 8'h3f, "control word write");
    wr(ADDR_MODE_CTRL, 16'h5a42);
    u_wdt_cpu_model.access(1'b1, XFER_BYTE, ADDR_MODE_CTRL, 16'h5a10);
    u_wdt_cpu_model.access(1'b1, XFER_LONG, ADDR_MODE_CTRL, 16'h5a11);
    wr(ADDR_MODE_CTRL, 16'h3c13);
    rdchk(ADDR_COUNT_RD, 8'h42, "count keyed write");
    u_wdt_cpu_model.access(1'b0, XFER_WORD, ADDR_COUNT_RD, 16'h0000);
    rdchk(ADDR_MODE_CTRL, 8'h3f, "wrong key ignored");
    wr(ADDR_MODE_CTRL, 16'ha518);
  endtask

  task automatic t_interval;
    wr(ADDR_MODE_CTRL, 16'ha520);
    wr(ADDR_MODE_CTRL, 16'h5aff);
    wait_for(1'b1);
    chk({7'h0, irq}, 8'h01, "interval interrupt");
    chk({7'h0, ovf_n}, 8'h01, "no overflow output");
    wr(ADDR_MODE_CTRL, 16'ha520);
    chk({7'h0, irq}, 8'h01, "clear without read");
    rdchk(ADDR_MODE_CTRL, 8'hb8, "interval flag read");
    wr(ADDR_MODE_CTRL, 16'ha5a0);
    chk({7'h0, irq}, 8'h01, "writing one kept");
    wr(ADDR_MODE_CTRL, 16'ha520);
    chk({7'h0, irq}, 8'h00, "flag cleared");
    wr(ADDR_MODE_CTRL, 16'ha518);
  endtask

  task automatic t_watchdog;
    wr(ADDR_RST_CTRL_WR, 16'h5a60);
    wr(ADDR_MODE_CTRL, 16'ha560);
    wr(ADDR_MODE_CTRL, 16'h5aff);
    wait_for(1'b0);
    chk({6'h0, chip_rst, man_rst}, 8'h03, "manual chip reset");
    chk({7'h0, irq}, 8'h00, "no interrupt in watchdog");
    repeat (600) @(posedge mclk);
    rdchk(ADDR_RST_CTRL_RD, 8'hff, "watchdog flag kept");
    rdchk(ADDR_MODE_CTRL, 8'h18, "control cleared");
    wr(ADDR_RST_CTRL_WR, 16'ha500);
    rdchk(ADDR_RST_CTRL_RD, 8'h7f, "watchdog flag clear");
    u_wdt_cpu_model.access(1'b1, XFER_BYTE, ADDR_RST_CTRL_WR, 16'h5a00);
    rdchk(ADDR_RST_CTRL_RD, 8'h7f, "byte write ignored");
    wr(ADDR_RST_CTRL_WR, 16'h5a00);
    rdchk(ADDR_RST_CTRL_RD, 8'h1f, "enable and select write");
  endtask

  // Power-on reset type, then an overflow with chip reset disabled
  task automatic t_reset_types;
    wr(ADDR_RST_CTRL_WR, 16'h5a5f);
    wr(ADDR_MODE_CTRL, 16'ha560);
    wr(ADDR_MODE_CTRL, 16'h5aff);
    wait_for(1'b0);
    chk({6'h0, chip_rst, man_rst}, 8'h02, "power-on chip reset");
    repeat (600) @(posedge mclk);
    wr(ADDR_RST_CTRL_WR, 16'h5a1f);
    wr(ADDR_MODE_CTRL, 16'ha560);
    wr(ADDR_MODE_CTRL, 16'h5aff);
    wait_for(1'b0);
    chk({6'h0, chip_rst, ovf_n}, 8'h00, "overflow without chip reset");
    rdchk(ADDR_MODE_CTRL, 8'h18, "control reset by overflow");
    rdchk(ADDR_COUNT_RD, 8'h00, "count reset by overflow");
    repeat (200) @(posedge mclk);
  endtask

  task automatic t_standby;
    wr(ADDR_MODE_CTRL, 16'ha547);
    wr(ADDR_RST_CTRL_WR, 16'h5a60);
    @(posedge mclk);
    standby <= 1'b1;
    @(posedge mclk);
    standby <= 1'b0;
    rdchk(ADDR_MODE_CTRL, 8'h1f, "standby keeps clock select");
    rdchk(ADDR_RST_CTRL_RD, 8'h1f, "standby reset control");
  endtask

  // ****************************************
  // Verdict
  // ****************************************
  task automatic results;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Whole run is under two thousand cycles
  initial begin
    #200000;
    num_errors++;
    $display("mismatch at %0t: run did not finish in time", $time);
    results();
  end

  initial begin
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
    t_reset_values();
    t_keyed_writes();
    t_interval();
    t_watchdog();
    t_reset_types();
    t_standby();
    results();
  end
endmodule

// >>> test/wdt_cpu_model.sv
// Partner model: software on the peripheral bus, one access at a time
module wdt_cpu_model
  import wdt_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Bus
  input wire logic [7:0] rdata_in,
  output bus_req_type req_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    req_out = '0;
  end

  // ****************************************
  // Bus cycles
  // ****************************************
  // Key and data travel in one word; released address and data lines show inverted values
  task automatic access(input logic w, input xfer_size_type s, input logic [27:0] a,
                        input logic [15:0] d);
    @(posedge clk_in);
    req_out <= '{1'b1, w, s, a, d};
    @(posedge clk_in);
    req_out <= '{1'b0, w, s, ~a, ~d};
  endtask

  // Byte reads only; data is settled one cycle after the taking edge
  task automatic rd(input logic [27:0] a, output logic [7:0] d);
    access(1'b0, XFER_BYTE, a, 16'h0000);
    @(posedge clk_in);
    #1;
    d = rdata_in;
  endtask
endmodule

// >>> test/wdt_top_asserts.sv
// Checker: port-level timing of the watchdog/interval timer
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  input wire logic BUS_VALID_IN,
  input wire logic BUS_WRITE_IN,
  input wire logic [1:0] BUS_SIZE_IN,
  input wire logic [27:0] BUS_ADDR_IN,
  input wire logic [7:0] BUS_RDATA_OUT,
  input wire logic BUS_HIT_OUT,
  input wire logic OVERFLOW_OUT_N_OUT,
  input wire logic CHIP_RESET_OUT,
  input wire logic MANUAL_RESET_OUT,
  input wire logic INTERVAL_INTERRUPT_OUT
);
  default clocking cb @(posedge MCLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  // ****************************************
  // Overflow actions
  // ****************************************
  // Run length of chip reset, too long for a plain delay
  logic [9:0] rst_run_q;

  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      rst_run_q <= 10'h000;
    end else if (CHIP_RESET_OUT) begin
      rst_run_q <= rst_run_q + 10'h001;
    end else begin
      rst_run_q <= 10'h000;
    end
  end

  property p_ovf_len;
    $fell(OVERFLOW_OUT_N_OUT) |-> ##127 !OVERFLOW_OUT_N_OUT ##1 OVERFLOW_OUT_N_OUT;
  endproperty
  a_ovf_len: assert property (p_ovf_len) else $error("overflow pulse length wrong");
  property p_rst_len;
    $fell(CHIP_RESET_OUT) |-> rst_run_q == CHIP_RST_COUNT;
  endproperty
  a_rst_len: assert property (p_rst_len) else $error("chip reset length wrong");
  property p_rst_max;
    rst_run_q <= CHIP_RST_COUNT;
  endproperty
  a_rst_max: assert property (p_rst_max) else $error("chip reset too long");
  property p_rst_with;
    $rose(CHIP_RESET_OUT) |-> $fell(OVERFLOW_OUT_N_OUT);
  endproperty
  a_rst_with: assert property (p_rst_with) else $error("chip reset without overflow");
  property p_manual;
    MANUAL_RESET_OUT |-> CHIP_RESET_OUT;
  endproperty
  a_manual: assert property (p_manual) else $error("manual reset alone");
  property p_mode;
    $rose(INTERVAL_INTERRUPT_OUT) |-> OVERFLOW_OUT_N_OUT && !$fell(OVERFLOW_OUT_N_OUT);
  endproperty
  a_mode: assert property (p_mode) else $error("interrupt and overflow together");

  // ****************************************
  // Reads and address hit
  // ****************************************
  property p_rsv_rst;
    BUS_VALID_IN && !BUS_WRITE_IN && BUS_SIZE_IN == 2'h0 && BUS_ADDR_IN == ADDR_RST_CTRL_RD
      |=> BUS_RDATA_OUT[4:0] == 5'h1f;
  endproperty
  a_rsv_rst: assert property (p_rsv_rst) else $error("reset control reserved bits");
  property p_rsv_ctl;
    BUS_VALID_IN && !BUS_WRITE_IN && BUS_SIZE_IN == 2'h0 && BUS_ADDR_IN == ADDR_MODE_CTRL
      |=> BUS_RDATA_OUT[4:3] == 2'h3;
  endproperty
  a_rsv_ctl: assert property (p_rsv_ctl) else $error("control reserved bits");
  property p_rd_refuse;
    BUS_VALID_IN && !BUS_WRITE_IN && BUS_SIZE_IN != 2'h0 |=> $stable(BUS_RDATA_OUT);
  endproperty
  a_rd_refuse: assert property (p_rd_refuse) else $error("wide read changed data");
  property p_hit;
    BUS_HIT_OUT == (BUS_VALID_IN && (BUS_ADDR_IN[27:2] == ADDR_MODE_CTRL[27:2]));
  endproperty
  a_hit: assert property (p_hit) else $error("address hit wrong");
endmodule

bind wdt_top wdt_checker u_wdt_checker (
  .MCLK_IN(MCLK_IN), .RESET_N_IN(RESET_N_IN), .BUS_VALID_IN(BUS_VALID_IN),
  .BUS_WRITE_IN(BUS_WRITE_IN), .BUS_SIZE_IN(BUS_SIZE_IN), .BUS_ADDR_IN(BUS_ADDR_IN),
  .BUS_RDATA_OUT(BUS_RDATA_OUT), .BUS_HIT_OUT(BUS_HIT_OUT),
  .OVERFLOW_OUT_N_OUT(OVERFLOW_OUT_N_OUT),
  .CHIP_RESET_OUT(CHIP_RESET_OUT), .MANUAL_RESET_OUT(MANUAL_RESET_OUT),
  .INTERVAL_INTERRUPT_OUT(INTERVAL_INTERRUPT_OUT)
);

// >>> verilog/wdt_pkg.sv
// Package: register map, field layout, reset values and timing of the watchdog/interval timer
package wdt_pkg;

  // ****************************************
  // Register addresses (byte addresses on the peripheral bus)
  // ****************************************
  localparam logic [27:0] ADDR_MODE_CTRL = 28'h5ffffb8;
  localparam logic [27:0] ADDR_COUNT_RD = 28'h5ffffb9;
  localparam logic [27:0] ADDR_RST_CTRL_WR = 28'h5ffffba;
  localparam logic [27:0] ADDR_RST_CTRL_RD = 28'h5ffffbb;

  // ****************************************
  // Write keys
  // ****************************************
  localparam logic [7:0] KEY_COUNT = 8'h5a;
  localparam logic [7:0] KEY_CTRL = 8'ha5;
  localparam logic [7:0] WATCHDOG_OVERFLOW_FLAG_CLEAR_DATA = 8'h00;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BIT_FLAG = 7;
  localparam int BIT_MODE = 6;
  localparam int BIT_ENABLE = 5;
  localparam int BIT_RST_SEL = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] MODE_CTRL_RESERVED = 8'h18;
  localparam logic [7:0] RST_CTRL_RESET = 8'h1f;
  localparam logic [7:0] COUNT_RESET = 8'h00;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 4;
  localparam int OVF_OUT_CYCLES = 128;
  localparam int CHIP_RST_CYCLES = 512;
  localparam int PRESCALE_WIDTH = 13;
  localparam logic [9:0] OVF_OUT_COUNT = 10'(OVF_OUT_CYCLES);
  localparam logic [9:0] CHIP_RST_COUNT = 10'(CHIP_RST_CYCLES);

  // ****************************************
  // Carriers
  // ****************************************
  typedef enum logic [1:0] {
    XFER_BYTE,
    XFER_WORD,
    XFER_LONG
  } xfer_size_type;

  typedef struct packed {
    logic valid;
    logic write;
    xfer_size_type size;
    logic [27:0] addr;
    logic [15:0] wdata;
  } bus_req_type;

  typedef struct packed {
    logic overflow_out_n;
    logic chip_reset;
    logic manual_reset;
    logic interval_interrupt;
  } timer_events_type;

endpackage

// >>> verilog/wdt_prescaler.sv
// Prescaler: divider that counts while run_in is high and clears while it is low, with a one-cycle tick on the selected tap
module wdt_prescaler
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic run_in,
  input wire logic [2:0] sel_in,
  // Tick
  output logic tick_out
);

  typedef struct packed {
    logic [PRESCALE_WIDTH-1:0] div;
  } pre_state_type;

  pre_state_type st_q;
  pre_state_type st_d;

  function automatic logic [3:0] tap_index(input logic [2:0] sel);
    case (sel)
      3'h0: tap_index = 4'h0;
      3'h1: tap_index = 4'h5;
      3'h2: tap_index = 4'h6;
      3'h3: tap_index = 4'h7;
      3'h4: tap_index = 4'h8;
      3'h5: tap_index = 4'h9;
      3'h6: tap_index = 4'hb;
      default: tap_index = 4'hc;
    endcase
  endfunction

  always_comb begin
    st_d = st_q;
    if (run_in) begin
      st_d.div = st_q.div + 13'h0001;
    end else begin
      st_d.div = '0;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Falling edge of the tap: one tick per 2^(n+1) cycles
  assign tick_out = run_in && st_q.div[tap_index(sel_in)] && !st_d.div[tap_index(sel_in)]; // [RQ7]

endmodule

// >>> verilog/wdt_pulse_timer.sv
// Pulse stretcher: holds an output for a fixed number of cycles after a start pulse
module wdt_pulse_timer
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Control
  input wire logic start_in,
  input wire logic [9:0] length_in,
  // Output
  output logic active_out
);

  typedef struct packed {
    logic [9:0] remain;
    logic active;
  } pulse_state_type;

  pulse_state_type st_q;
  pulse_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (start_in) begin
      st_d.remain = length_in - 10'h001;
      st_d.active = 1'b1;
    end else if (st_q.active) begin
      if (st_q.remain == 10'h000) begin
        st_d.active = 1'b0;
      end else begin
        st_d.remain = st_q.remain - 10'h001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign active_out = st_q.active;

endmodule

// >>> verilog/wdt_top.sv
// Watchdog / interval timer: registers, counter, overflow actions
// Summary of operation
// [RQ1] Mode bits clear on reset/standby; clock select survives standby
// [RQ2] Interval flag sets on wrap, interval mode only
// [RQ3] Interval flag cleared by read-one-then-write-zero
// [RQ4] Mode bit routes overflow: interrupt or overflow output
// [RQ5] Disabled timer holds count at zero
// [RQ6] Reserved bits read as one
// [RQ7] Clock select picks one of eight dividers
// [RQ8] Reset control loads 1f; kept over watchdog reset
// [RQ9] Watchdog flag sets on wrap in watchdog mode
// [RQ10] Key a5 with data 00 clears watchdog flag
// [RQ11] No reset enable: clear counter and control only
// [RQ12] Reset select picks power-on or manual reset
// [RQ13] Shared write address, key picks counter or control
// [RQ14] Byte writes to counter/control ignored
// [RQ15] Key 5a writes reset enable and select
// [RQ16] Reset control written by word only
// [RQ17] Byte reads at base, base+1, base+3
// [RQ18] Eight-bit up-counter, wrap is overflow
// [RQ19] Overflow output held 128 cycles
// [RQ20] Internal chip reset held 512 cycles
// [RQ21] Counter write beats simultaneous increment
// [RQ22] Interrupt follows the interval flag
module wdt_top
  import wdt_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic RESET_N_IN,
  // Standby entry, a level from the power controller on this clock
  input wire logic STANDBY_IN,
  // Peripheral bus
  input wire logic BUS_VALID_IN,
  input wire logic BUS_WRITE_IN,
  input wire logic [1:0] BUS_SIZE_IN,
  input wire logic [27:0] BUS_ADDR_IN,
  input wire logic [15:0] BUS_WDATA_IN,
  output logic [7:0] BUS_RDATA_OUT,
  output logic BUS_HIT_OUT,
  // Overflow actions
  output logic OVERFLOW_OUT_N_OUT,
  output logic CHIP_RESET_OUT,
  output logic MANUAL_RESET_OUT,
  output logic INTERVAL_INTERRUPT_OUT
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic ovf_flag;
    logic mode_wdt;
    logic enable;
    logic [2:0] clk_sel;
    logic [7:0] count;
    logic watchdog_overflow_flag_flag;
    logic rst_enable;
    logic rst_select;
    logic ovf_seen;
    logic watchdog_overflow_flag_seen;
    logic manual_rst;
    logic [7:0] rdata;
  } wdt_state_type;

  wdt_state_type st_q;
  wdt_state_type st_d;

  bus_req_type req;
  logic tick;
  logic wrap;
  logic wdt_ovf;
  logic word_wr;
  logic byte_rd;
  logic count_wr;
  logic ovf_active;
  logic rst_active;

  function automatic logic [7:0] mode_ctrl_read(input wdt_state_type s);
    mode_ctrl_read = MODE_CTRL_RESERVED; // [RQ6]
    mode_ctrl_read[BIT_FLAG] = s.ovf_flag;
    mode_ctrl_read[BIT_MODE] = s.mode_wdt;
    mode_ctrl_read[BIT_ENABLE] = s.enable;
    mode_ctrl_read[2:0] = s.clk_sel;
  endfunction

  function automatic logic [7:0] rst_ctrl_read(input wdt_state_type s);
    rst_ctrl_read = RST_CTRL_RESET; // [RQ6]
    rst_ctrl_read[BIT_FLAG] = s.watchdog_overflow_flag_flag;
    rst_ctrl_read[BIT_MODE] = s.rst_enable;
    rst_ctrl_read[BIT_RST_SEL] = s.rst_select;
  endfunction

  // ****************************************
  // Bus decode
  // ****************************************
  always_comb begin
    req.valid = BUS_VALID_IN;
    req.write = BUS_WRITE_IN;
    req.size = xfer_size_type'(BUS_SIZE_IN);
    req.addr = BUS_ADDR_IN;
    req.wdata = BUS_WDATA_IN;
  end

  // Byte or long writes never qualify
  assign word_wr = req.valid && req.write && (req.size == XFER_WORD); // [RQ14] [RQ16]
  assign byte_rd = req.valid && !req.write && (req.size == XFER_BYTE); // [RQ17]
  assign count_wr = word_wr && (req.addr == ADDR_MODE_CTRL) && (req.wdata[15:8] == KEY_COUNT);

  assign BUS_HIT_OUT = req.valid && ((req.addr == ADDR_MODE_CTRL) || (req.addr == ADDR_COUNT_RD)
    || (req.addr == ADDR_RST_CTRL_WR) || (req.addr == ADDR_RST_CTRL_RD));

  // ****************************************
  // Prescaler and pulse timers
  // ****************************************
  wdt_prescaler u_prescaler (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .run_in(st_q.enable),
    .sel_in(st_q.clk_sel),
    .tick_out(tick)
  );

  // A count write suppresses the increment, so no wrap either
  assign wrap = tick && st_q.enable && (st_q.count == 8'hff) && !count_wr; // [RQ18] [RQ21]
  assign wdt_ovf = wrap && st_q.mode_wdt;

  wdt_pulse_timer u_ovf_pulse (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .start_in(wdt_ovf),
    .length_in(OVF_OUT_COUNT), // [RQ19]
    .active_out(ovf_active)
  );

  wdt_pulse_timer u_rst_pulse (
    .clk_in(MCLK_IN),
    .rst_n_in(RESET_N_IN),
    .start_in(wdt_ovf && st_q.rst_enable), // [RQ20]
    .active_out(rst_active),
    .length_in(CHIP_RST_COUNT)
  );

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    st_d.rdata = st_q.rdata;
    // Counter advance; a key write below overrides it
    if (!st_q.enable) begin
      st_d.count = COUNT_RESET; // [RQ5]
    end else if (tick) begin
      st_d.count = st_q.count + 8'h01; // [RQ18]
    end
    // Reads: capture data and arm the read-before-clear guard
    if (byte_rd) begin
      if (req.addr == ADDR_MODE_CTRL) begin
        st_d.rdata = mode_ctrl_read(st_q);
        if (st_q.ovf_flag) begin
          st_d.ovf_seen = 1'b1; // [RQ3]
        end
      end else if (req.addr == ADDR_COUNT_RD) begin
        st_d.rdata = st_q.count;
      end else if (req.addr == ADDR_RST_CTRL_RD) begin
        st_d.rdata = rst_ctrl_read(st_q);
        if (st_q.watchdog_overflow_flag_flag) begin
          st_d.watchdog_overflow_flag_seen = 1'b1;
        end
      end else begin
        st_d.rdata = 8'h00;
      end
    end
    if (word_wr && req.addr == ADDR_MODE_CTRL) begin
      if (req.wdata[15:8] == KEY_COUNT) begin
        st_d.count = req.wdata[7:0]; // [RQ13] [RQ21]
      end else if (req.wdata[15:8] == KEY_CTRL) begin
        st_d.mode_wdt = req.wdata[BIT_MODE]; // [RQ13]
        st_d.enable = req.wdata[BIT_ENABLE];
        st_d.clk_sel = req.wdata[2:0];
        if (!req.wdata[BIT_ENABLE]) begin
          st_d.count = COUNT_RESET; // [RQ5]
        end
        // Writing one to the flag has no effect
        if (!req.wdata[BIT_FLAG] && st_q.ovf_seen) begin
          st_d.ovf_flag = 1'b0; // [RQ3]
          st_d.ovf_seen = 1'b0;
        end
      end
    end
    if (word_wr && req.addr == ADDR_RST_CTRL_WR) begin
      if (req.wdata[15:8] == KEY_CTRL && req.wdata[7:0] == WATCHDOG_OVERFLOW_FLAG_CLEAR_DATA) begin
        if (st_q.watchdog_overflow_flag_seen) begin
          st_d.watchdog_overflow_flag_flag = 1'b0; // [RQ10]
          st_d.watchdog_overflow_flag_seen = 1'b0;
        end
      end else if (req.wdata[15:8] == KEY_COUNT) begin
        st_d.rst_enable = req.wdata[BIT_MODE]; // [RQ15]
        st_d.rst_select = req.wdata[BIT_RST_SEL];
      end
    end
    // Overflow events; set wins over a same-cycle write clear, a standby below still clears
    if (wrap && !st_q.mode_wdt) begin
      st_d.ovf_flag = 1'b1; // [RQ2] [RQ4]
    end
    if (wdt_ovf) begin
      st_d.watchdog_overflow_flag_flag = 1'b1; // [RQ9]
      st_d.manual_rst = st_q.rst_select; // [RQ12]
      // Timer-local reset of counter and control, reset control kept
      st_d.count = COUNT_RESET; // [RQ11] [RQ8]
      st_d.ovf_flag = 1'b0;
      st_d.mode_wdt = 1'b0;
      st_d.enable = 1'b0;
      st_d.clk_sel = 3'h0;
      st_d.ovf_seen = 1'b0;
    end
    // Standby: upper control bits and reset control reinitialise, clock select kept
    if (STANDBY_IN) begin
      st_d.ovf_flag = 1'b0; // [RQ1]
      st_d.mode_wdt = 1'b0;
      st_d.enable = 1'b0;
      st_d.ovf_seen = 1'b0;
      st_d.watchdog_overflow_flag_flag = RST_CTRL_RESET[BIT_FLAG]; // [RQ8]
      st_d.rst_enable = RST_CTRL_RESET[BIT_MODE];
      st_d.rst_select = RST_CTRL_RESET[BIT_RST_SEL];
      st_d.watchdog_overflow_flag_seen = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  // The pin reset clears everything; the chip reset issued here does not feed back
  always_ff @(posedge MCLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      st_q <= '0; // [RQ1]
      st_q.count <= COUNT_RESET;
      st_q.watchdog_overflow_flag_flag <= RST_CTRL_RESET[BIT_FLAG]; // [RQ8]
      st_q.rst_enable <= RST_CTRL_RESET[BIT_MODE];
      st_q.rst_select <= RST_CTRL_RESET[BIT_RST_SEL];
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign BUS_RDATA_OUT = st_q.rdata;
  assign OVERFLOW_OUT_N_OUT = !ovf_active; // [RQ4] [RQ19]
  assign CHIP_RESET_OUT = rst_active; // [RQ11] [RQ20]
  assign MANUAL_RESET_OUT = rst_active && st_q.manual_rst; // [RQ12]
  assign INTERVAL_INTERRUPT_OUT = st_q.ovf_flag; // [RQ22]

endmodule
